// ### design/imcs_consts.vh
`ifndef IMCS_CONSTS_VH
`define IMCS_CONSTS_VH

// register byte addresses on the plain register port
`define IMCS_ADDR_GROUP_SIX     32'hFFFFE018
`define IMCS_ADDR_GROUP_SEVEN   32'hFFFFE01C
`define IMCS_ADDR_EVT_STATUS    32'hFFFFE0F0
`define IMCS_ADDR_EVT_MASK      32'hFFFFE0F4

// per-source byte layout inside a mode control word
`define IMCS_FLD_BYTE_W         8
`define IMCS_FLD_EDGE_HI        5
`define IMCS_FLD_EDGE_LO        4
`define IMCS_FLD_DMA            3
`define IMCS_FLD_LEVEL_HI       2
`define IMCS_FLD_LEVEL_LO       0
`define IMCS_FLD_USED_MASK      8'h3F

// encodings
`define IMCS_EDGE_RISING        2'h3
`define IMCS_LEVEL_OFF          3'h0

// reset values
`define IMCS_RST_MODE           32'h00000000
`define IMCS_RST_STATUS         9'h000
`define IMCS_RST_MASK           9'h000

// event status layout: one bit per source, then the bad-sensitivity flag
`define IMCS_EVT_BAD_EDGE_BIT   8
`define IMCS_EVT_W              9

`endif

// ### design/imcs_src_slice.v
`timescale 1ns/1ps
`include "imcs_consts.vh"

module imcs_src_slice (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       src_req,
  input  wire [1:0] edge_sel,
  input  wire       dma_route,
  input  wire [2:0] level,
  output wire       cpu_evt,
  output wire       dma_evt,
  output wire [2:0] dma_chan
);

  reg prev_q;

  // previous sample of the request for edge detection
  always @(posedge clk) begin
    if (!rst_b)
      prev_q <= 1'b0;
    else
      prev_q <= src_req;
  end

  // only the rising-edge code detects; prohibited codes stay silent
  wire rise = src_req & ~prev_q & (edge_sel == `IMCS_EDGE_RISING);

  // routed to dma: no cpu event, field picks the channel
  assign dma_evt  = rise & dma_route;
  assign cpu_evt  = rise & ~dma_route & (level != `IMCS_LEVEL_OFF);
  assign dma_chan = level;

endmodule // imcs_src_slice

// ### design/imcs_top.v
// Overview of operation
// - sensitivity field must be 11 (rising edge); other codes are prohibited.
// - source 25 select bit: 0 normal interrupt, 1 request is a dma trigger.
// - source 24 has its own select bit with the same meaning.
// - select clear: three-bit field is priority, 000 disables, 001-111 levels 1-7.
// - select set: three-bit field picks dma channel 0 to 7.
`timescale 1ns/1ps
`include "imcs_consts.vh"

module imcs_top #(
  parameter NUM_SRC  = 8,
  parameter NUM_CHAN = 8,
  parameter SRC_BASE = 24
) (
  input  wire        REF_CLK,
  input  wire        RST_B,
  input  wire [31:0] ADDR,
  input  wire [31:0] WR_DATA,
  input  wire        WR_STB,
  input  wire        RD_STB,
  output reg  [31:0] RD_DATA,
  input  wire [7:0]  SRC_REQ,
  output reg         IRQ,
  output reg  [7:0]  SRC_PEND_LEVEL_OK,
  output reg  [7:0]  DMA_REQ
);

  localparam EW = `IMCS_EVT_W;

  // mode control words: index 0 holds sources 24..27, index 1 sources 28..31
  reg  [31:0]    mode_q [0:1];
  reg  [EW-1:0]  status_q;
  reg  [EW-1:0]  status_d;
  reg  [EW-1:0]  mask_q;
  reg  [7:0]     cpu_set;
  reg  [7:0]     dma_d;
  reg            bad_edge_set;
  reg  [31:0]    rd_d;
  wire [7:0]     cpu_evt;
  wire [7:0]     dma_evt;
  wire [23:0]    dma_chan;
  wire [7:0]     lvl_ok;
  integer        i;
  integer        k;

  // address decode shared by read and write paths
  function [2:0] addr_sel;
    input [31:0] a;
    begin
      if (a == `IMCS_ADDR_GROUP_SIX)
        addr_sel = 3'h1;
      else if (a == `IMCS_ADDR_GROUP_SEVEN)
        addr_sel = 3'h2;
      else if (a == `IMCS_ADDR_EVT_STATUS)
        addr_sel = 3'h3;
      else if (a == `IMCS_ADDR_EVT_MASK)
        addr_sel = 3'h4;
      else
        addr_sel = 3'h0;
    end
  endfunction

  // any source byte whose sensitivity is not the rising-edge code
  function bad_edge_word;
    input [31:0] w;
    integer b;
    begin
      bad_edge_word = 1'b0;
      for (b = 0; b < 4; b = b + 1) begin
        if (w[b*8+`IMCS_FLD_EDGE_LO +: 2] != `IMCS_EDGE_RISING)
          bad_edge_word = 1'b1;
      end
    end
  endfunction

  // pick the byte of one source out of the two mode words
  function [7:0] src_byte;
    input [31:0] w6;
    input [31:0] w7;
    input integer s;
    begin
      if (s < 4)
        src_byte = w6[s*8 +: 8];
      else
        src_byte = w7[(s-4)*8 +: 8];
    end
  endfunction

  // one detector per source; its byte steers edge, routing and level
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_src
      wire [7:0] cfg = src_byte(mode_q[0], mode_q[1], g);
      // cpu routed with a non-zero level: able to interrupt the processor
      assign lvl_ok[g] = ~cfg[`IMCS_FLD_DMA] &
                         (cfg[`IMCS_FLD_LEVEL_HI:`IMCS_FLD_LEVEL_LO] != `IMCS_LEVEL_OFF);
      imcs_src_slice u_slice (
        .clk       (REF_CLK),
        .rst_b     (RST_B),
        .src_req   (SRC_REQ[g]),
        .edge_sel  (cfg[`IMCS_FLD_EDGE_HI:`IMCS_FLD_EDGE_LO]),
        .dma_route (cfg[`IMCS_FLD_DMA]),
        .level     (cfg[`IMCS_FLD_LEVEL_HI:`IMCS_FLD_LEVEL_LO]),
        .cpu_evt   (cpu_evt[g]),
        .dma_evt   (dma_evt[g]),
        .dma_chan  (dma_chan[g*3 +: 3])
      );
    end
  endgenerate

  // mode words: unused top bits of each byte are kept at zero
  always @(posedge REF_CLK) begin
    if (!RST_B) begin
      mode_q[0] <= `IMCS_RST_MODE;
      mode_q[1] <= `IMCS_RST_MODE;
    end else if (WR_STB && addr_sel(ADDR) == 3'h1) begin
      mode_q[0] <= WR_DATA & {4{`IMCS_FLD_USED_MASK}};
    end else if (WR_STB && addr_sel(ADDR) == 3'h2) begin
      mode_q[1] <= WR_DATA & {4{`IMCS_FLD_USED_MASK}};
    end
  end

  // events and the bad-sensitivity flag; a set in the clearing cycle wins
  always @* begin
    cpu_set      = cpu_evt;
    bad_edge_set = WR_STB && (addr_sel(ADDR) == 3'h1 || addr_sel(ADDR) == 3'h2)
                   && bad_edge_word(WR_DATA);
    status_d     = status_q;
    if (WR_STB && addr_sel(ADDR) == 3'h3)
      status_d = status_q & ~WR_DATA[EW-1:0];
    status_d = status_d | {bad_edge_set, cpu_set};
  end

  always @(posedge REF_CLK) begin
    if (!RST_B) begin
      status_q <= `IMCS_RST_STATUS;
      mask_q   <= `IMCS_RST_MASK;
    end else begin
      status_q <= status_d;
      if (WR_STB && addr_sel(ADDR) == 3'h4)
        mask_q <= WR_DATA[EW-1:0];
    end
  end

  // dma channel requests: several sources on one channel merge into one pulse
  always @* begin
    dma_d = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      for (k = 0; k < NUM_CHAN; k = k + 1) begin
        if (dma_evt[i] && dma_chan[i*3 +: 3] == k[2:0])
          dma_d[k] = 1'b1;
      end
    end
  end

  // read mux; data stands only in the cycle after the strobe
  always @* begin
    rd_d = 32'h00000000;
    if (RD_STB) begin
      case (addr_sel(ADDR))
        3'h1:    rd_d = mode_q[0];
        3'h2:    rd_d = mode_q[1];
        3'h3:    rd_d = {23'h000000, status_q};
        3'h4:    rd_d = {23'h000000, mask_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // all outputs registered; irq follows next status so it tracks the bit
  always @(posedge REF_CLK) begin
    if (!RST_B) begin
      RD_DATA           <= 32'h00000000;
      IRQ               <= 1'b0;
      DMA_REQ           <= 8'h00;
      SRC_PEND_LEVEL_OK <= 8'h00;
    end else begin
      RD_DATA <= rd_d;
      IRQ     <= |(status_d & (WR_STB && addr_sel(ADDR) == 3'h4 ?
                               WR_DATA[EW-1:0] : mask_q));
      DMA_REQ <= dma_d;
      // sources able to interrupt the processor (cpu routed, level set)
      SRC_PEND_LEVEL_OK <= lvl_ok;
    end
  end

endmodule // imcs_top

// ### bench/imcs_top_asserts.sv
`timescale 1ns/1ps
module imcs_chk (
  input wire        REF_CLK,
  input wire        RST_B,
  input wire [31:0] ADDR,
  input wire        WR_STB,
  input wire        RD_STB,
  input wire [31:0] RD_DATA,
  input wire [7:0]  SRC_REQ,
  input wire        IRQ,
  input wire [7:0]  SRC_PEND_LEVEL_OK,
  input wire [7:0]  DMA_REQ
);
  reg  [7:0] req_q;
  wire [7:0] rise;
  // own copy of the previous sample, so edges are judged apart from the design
  always @(posedge REF_CLK) begin
    req_q <= RST_B ? SRC_REQ : 8'h00;
  end
  assign rise = SRC_REQ & ~req_q;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  rst_quiet_a: assert property ($past(!RST_B) |-> !IRQ && DMA_REQ == 8'h00)
    else $error("outputs busy after reset");
  rd_idle_a: assert property (!$past(RD_STB) |-> RD_DATA == 32'h0)
    else $error("read data outside slot");
  rd_unmap_a: assert property ($past(RD_STB) && $past(ADDR) == 32'hFFFFE000 |-> RD_DATA == 32'h0)
    else $error("unmapped read not zero");
  dma_cause_a: assert property (DMA_REQ != 8'h00 |-> $past(rise) != 8'h00)
    else $error("dma request without edge");
  dma_pulse_a: assert property (DMA_REQ != 8'h00 |=> DMA_REQ == 8'h00 || $past(rise) != 8'h00)
    else $error("dma request held");
  irq_rise_a: assert property ($rose(IRQ) |-> $past(WR_STB) || $past(rise) != 8'h00)
    else $error("irq without cause");
  irq_fall_a: assert property ($fell(IRQ) |-> $past(WR_STB))
    else $error("irq dropped by itself");
  level_cfg_a: assert property (!$past(WR_STB, 2) |-> $stable(SRC_PEND_LEVEL_OK))
    else $error("level flags moved without write");
endmodule // imcs_chk

// ### bench/imcs_far.sv
`timescale 1ns/1ps
module imcs_far (
  input  wire       clk,
  input  wire       rst_b,
  input  wire [7:0] fire,
  input  wire [7:0] dma_req,
  output reg  [7:0] src_req_q,
  output reg  [7:0] seen_q
);
  // one-cycle source pulses; channels collect pulses, a new shot starts afresh
  always @(posedge clk) begin
    src_req_q <= rst_b ? fire : 8'h00;
    seen_q    <= (!rst_b || fire != 8'h00) ? 8'h00 : seen_q | dma_req;
  end
endmodule // imcs_far

// ### bench/tb_imcs_top.sv
`timescale 1ns/1ps
`include "imcs_consts.vh"
module tb_imcs_top;
  reg         REF_CLK = 1'b0, RST_B = 1'b0, WR_STB = 1'b0, RD_STB = 1'b0;
  reg  [31:0] ADDR = 32'h0, WR_DATA = 32'h0, d;
  reg  [7:0]  fire = 8'h00, b, xd, xl;
  reg  [8:0]  mk, xs;
  wire [31:0] RD_DATA;
  wire        IRQ;
  wire [7:0]  SRC_REQ, SRC_PEND_LEVEL_OK, DMA_REQ, seen;
  integer     seed = 93, num_errors = 0, checks_done = 0, k, i;
  imcs_top i_dut (.*);
  imcs_far i_far (.clk(REF_CLK), .rst_b(RST_B), .fire(fire), .dma_req(DMA_REQ),
    .src_req_q(SRC_REQ), .seen_q(seen));
  initial forever #5 REF_CLK = ~REF_CLK;
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] v);
    begin
      @(posedge REF_CLK);
      ADDR <= a;
      WR_DATA <= v;
      WR_STB <= 1'b1;
      @(posedge REF_CLK);
      WR_STB <= 1'b0;
    end
  endtask
  task rdchk(input [31:0] a, input [31:0] e);
    begin
      @(posedge REF_CLK);
      ADDR <= a;
      RD_STB <= 1'b1;
      @(posedge REF_CLK);
      RD_STB <= 1'b0;
      #1 chk(RD_DATA, e);
    end
  endtask
  // shoot sources, then compare channels, flags, irq and status, then clear
  task shoot(input [7:0] f);
    begin
      @(posedge REF_CLK);
      fire <= f;
      @(posedge REF_CLK);
      fire <= 8'h00;
      repeat (3) @(posedge REF_CLK);
      #1 chk(seen, xd);
      chk(SRC_PEND_LEVEL_OK, xl);
      chk(IRQ, |(xs & mk));
      rdchk(`IMCS_ADDR_EVT_STATUS, xs);
      wr(`IMCS_ADDR_EVT_STATUS, 32'h1FF);
      repeat (2) @(posedge REF_CLK);
      #1 chk(IRQ, 1'b0);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge REF_CLK);
    RST_B <= 1'b1;
    rdchk(`IMCS_ADDR_GROUP_SIX, 32'h0);
    rdchk(`IMCS_ADDR_GROUP_SEVEN, 32'h0);
    rdchk(`IMCS_ADDR_EVT_MASK, 32'h0);
    $display("test reset values done");
    // every select and level code on source 24, random fields elsewhere
    for (k = 0; k < 16; k = k + 1) begin
      d = ($random(seed) & 32'hCFCFCFC0) | 32'h30303030 | k;
      mk = $random(seed);
      wr(`IMCS_ADDR_GROUP_SIX, d);
      wr(`IMCS_ADDR_EVT_MASK, mk);
      rdchk(`IMCS_ADDR_GROUP_SIX, d & 32'h3F3F3F3F);
      xd = 8'h00;
      xl = 8'h00;
      xs = 9'h000;
      for (i = 0; i < 4; i = i + 1) begin
        b = d >> (8 * i);
        if (b[3])
          xd[b[2:0]] = 1'b1;
        else if (b[2:0] != 3'h0) begin
          xl[i] = 1'b1;
          xs[i] = 1'b1;
        end
      end
      shoot(8'h0F);
    end
    $display("test routing done");
    // prohibited sensitivity: flagged, and the edge is ignored
    mk = 9'h1FF;
    wr(`IMCS_ADDR_EVT_MASK, mk);
    wr(`IMCS_ADDR_GROUP_SIX, 32'h0);
    wr(`IMCS_ADDR_GROUP_SEVEN, 32'h1A000000);
    xd = 8'h00;
    xl = 8'h00;
    xs = 9'h100;
    shoot(8'h80);
    // source 31 to channel 2; lower bytes still carry code 00
    wr(`IMCS_ADDR_GROUP_SEVEN, 32'h3A000000);
    xd = 8'h04;
    shoot(8'h80);
    $display("test edge field done");
    wr(32'hFFFFE000, $random(seed));
    rdchk(32'hFFFFE000, 32'h0);
    $display("test unmapped done");
    report_and_stop;
  end
endmodule // tb_imcs_top
bind imcs_top imcs_chk i_chk (.*);
